// file: nvac_top.sv
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module nvac_top
  import nvac_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_CYCLES_P  = POWER_UP_TIMER_CYCLES,
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  // Clock, reset and freeze.
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Register port.
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  // Configuration bit, low means protected.
  input  wire logic              data_code_protect_n,
  // Non-processor access path.
  input  wire logic              ext_req,
  input  wire logic              ext_we,
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic [DATA_W-1:0] ext_wdata,
  output var  logic              ext_ack,
  output var  logic              ext_denied,
  output var  logic [DATA_W-1:0] ext_rdata,
  // Interrupt.
  output var  logic              irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  nvac_mem_if mu ();

  logic              power_up_timer_busy;
  logic              cp_meta;
  logic              cp_sync;
  logic              prot;
  logic              bus_wr;
  logic              bus_rd;
  logic              addr_wr;
  logic              data_wr;
  logic              ctrl_wr;
  logic              unlock_acc;
  logic              status_wr;
  logic              mask_wr;
  logic              ul_expect;
  logic              ul_armed;
  logic              rd_go;
  logic              wr_go;
  logic              wr_done;
  logic              ext_go;
  logic              ext_deny;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic              data_src_mem;
  logic [DATA_W-1:0] data_view;
  logic              pgd_reg;
  logic              config_space_select_reg;
  logic              write_enable_bit_reg;
  logic              wr_bit;
  logic [CNT_W-1:0]  wcnt_reg;
  logic              done_flag;
  logic              mask_bit;
  logic              ext_ack_reg;
  logic              ext_denied_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  nvac_unlock_t      ul_state;
  nvac_unlock_t      ul_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Leaf modules.

  nvac_mem u_mem (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .mp    (mu.mem)
  );

  nvac_power_up_timer #(
    .CYCLES (POWER_UP_TIMER_CYCLES_P)
  ) u_power_up_timer (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .busy  (power_up_timer_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Protection pin and bus decode.

  // The configuration level comes from outside, so it is synchronised.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cp_meta <= 1'b0;
      cp_sync <= 1'b0;
    end else if (ce) begin
      cp_meta <= data_code_protect_n;
      cp_sync <= cp_meta;
    end
  end

  // Until the synchroniser settles after reset, the array counts as protected.
  assign prot       = ~cp_sync;
  assign bus_wr     = reg_wr & ce;
  assign bus_rd     = reg_rd & ce;
  assign addr_wr    = bus_wr && (reg_addr == OFS_ADDR);
  assign data_wr    = bus_wr && (reg_addr == OFS_DATA);
  assign ctrl_wr    = bus_wr && (reg_addr == OFS_CTRL);
  assign status_wr  = bus_wr && (reg_addr == OFS_STATUS);
  assign mask_wr    = bus_wr && (reg_addr == OFS_MASK);
  assign unlock_acc = (bus_wr || bus_rd) && (reg_addr == OFS_UNLOCK);

  ////////////////////////////////////////////////////////////////////////////////
  // Unlock tracker.

  // A unlock write counts only if it carries the key expected next.
  always_comb begin
    ul_expect = 1'b0;
    if (bus_wr && (reg_addr == OFS_UNLOCK)) begin
      if (ul_state == NVAC_UL_IDLE) begin
        ul_expect = (reg_wdata == UNLOCK_KEY1);
      end else if (ul_state == NVAC_UL_KEY1) begin
        ul_expect = (reg_wdata == UNLOCK_KEY2);
      end
    end
  end

  // Any other unlock access, and any control write, starts over.
  always_comb begin
    ul_next = ul_state;
    if (ctrl_wr) begin
      ul_next = NVAC_UL_IDLE;
    end else if (unlock_acc) begin
      case (ul_state)
        NVAC_UL_IDLE:  ul_next = ul_expect ? NVAC_UL_KEY1 : NVAC_UL_IDLE;
        NVAC_UL_KEY1:  ul_next = ul_expect ? NVAC_UL_ARMED : NVAC_UL_IDLE;
        default:       ul_next = NVAC_UL_IDLE;
      endcase
    end
  end

  // Tracker state; frozen with everything else while the enable is low.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ul_state <= NVAC_UL_IDLE;
    end else if (ce) begin
      ul_state <= ul_next;
    end
  end

  assign ul_armed = (ul_state == NVAC_UL_ARMED);

  ////////////////////////////////////////////////////////////////////////////////
  // Start conditions and array port.

  // Reads need both space selects clear; protection is not consulted.
  assign rd_go = ctrl_wr && reg_wdata[CTRL_RD] && !reg_wdata[CTRL_PGD] &&
                 !reg_wdata[CTRL_CONFIG_SPACE_SELECT] && !wr_bit;

  // The write bit only takes when armed, enabled and the timer is done.
  assign wr_go = ctrl_wr && reg_wdata[CTRL_WR] && ul_armed && write_enable_bit_reg && !wr_bit &&
                 !power_up_timer_busy && !reg_wdata[CTRL_PGD] && !reg_wdata[CTRL_CONFIG_SPACE_SELECT];

  // The outside path only gets the array when unprotected and idle.
  assign ext_deny = ext_req && prot && ce && !ext_ack_reg && !ext_denied_reg;
  assign ext_go   = ext_req && !prot && ce && !ext_ack_reg && !ext_denied_reg &&
                    !wr_bit && !rd_go && !wr_go;

  // The array is written at the start; the timer then models the cell time.
  assign mu.re    = rd_go || (ext_go && !ext_we);
  assign mu.we    = wr_go || (ext_go && ext_we);
  assign mu.addr  = (rd_go || wr_go) ? addr_reg : ext_addr;
  assign mu.wdata = wr_go ? data_view : ext_wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data registers.

  // Address register, loaded by software before either access.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      addr_reg <= RST_BYTE;
    end else if (addr_wr) begin
      addr_reg <= reg_wdata;
    end
  end

  // After a read the data register shows the array output directly, so the
  // byte is visible the very next cycle without a second copy.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_reg     <= RST_BYTE;
      data_src_mem <= 1'b0;
    end else if (data_wr) begin
      data_reg     <= reg_wdata;
      data_src_mem <= 1'b0;
    end else if (rd_go) begin
      data_src_mem <= 1'b1;
    end else if (ext_go && !ext_we && data_src_mem) begin
      data_reg     <= mu.rdata;
      data_src_mem <= 1'b0;
    end
  end

  assign data_view = data_src_mem ? mu.rdata : data_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register.

  // Only software or reset ever changes the enable and select bits.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pgd_reg  <= 1'b0;
      config_space_select_reg <= 1'b0;
      write_enable_bit_reg <= 1'b0;
    end else if (ctrl_wr) begin
      pgd_reg  <= reg_wdata[CTRL_PGD];
      config_space_select_reg <= reg_wdata[CTRL_CONFIG_SPACE_SELECT];
      write_enable_bit_reg <= reg_wdata[CTRL_WRITE_ENABLE_BIT];
    end
  end

  // Write cycle timer; clearing the enable does not stop it.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_bit   <= 1'b0;
      wcnt_reg <= '0;
    end else if (ce) begin
      if (wr_go) begin
        wr_bit   <= 1'b1;
        wcnt_reg <= CNT_W'(WRITE_CYCLES_P - 1);
      end else if (wr_done) begin
        wr_bit   <= 1'b0;
      end else if (wr_bit) begin
        wcnt_reg <= wcnt_reg - 1'b1;
      end
    end
  end

  assign wr_done = ce && wr_bit && (wcnt_reg == '0);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  // The done flag is sticky; a completion in the clearing cycle wins.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      done_flag <= 1'b0;
    end else if (wr_done) begin
      done_flag <= 1'b1;
    end else if (status_wr && reg_wdata[STAT_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // Mask register; polling software may leave it clear.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mask_bit <= 1'b0;
    end else if (mask_wr) begin
      mask_bit <= reg_wdata[STAT_DONE];
    end
  end

  assign irq = done_flag & mask_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Outside path answers.

  // One answer per request; the requester drops its request after it.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ext_ack_reg    <= 1'b0;
      ext_denied_reg <= 1'b0;
    end else if (ce) begin
      ext_ack_reg    <= ext_go;
      ext_denied_reg <= ext_deny;
    end
  end

  assign ext_ack    = ext_ack_reg;
  assign ext_denied = ext_denied_reg;
  assign ext_rdata  = mu.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read-back.

  // Unmapped offsets and the unlock register read as zero.
  always_comb begin
    rdata_next = RST_BYTE;
    case (reg_addr)
      OFS_ADDR:   rdata_next = addr_reg;
      OFS_DATA:   rdata_next = data_view;
      OFS_CTRL: begin
        rdata_next[CTRL_PGD]  = pgd_reg;
        rdata_next[CTRL_CONFIG_SPACE_SELECT] = config_space_select_reg;
        rdata_next[CTRL_WRITE_ENABLE_BIT] = write_enable_bit_reg;
        rdata_next[CTRL_WR]   = wr_bit;
      end
      OFS_STATUS: rdata_next[STAT_DONE] = done_flag;
      OFS_MASK:   rdata_next[STAT_DONE] = mask_bit;
      default:    rdata_next = RST_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_reg <= RST_BYTE;
    end else if (ce) begin
      rdata_reg <= bus_rd ? rdata_next : RST_BYTE;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !ce);

  sequence s_key1_taken;
    ul_expect && (ul_state == NVAC_UL_IDLE);
  endsequence

  sequence s_key2_taken;
    ul_expect && (ul_state == NVAC_UL_KEY1);
  endsequence

  AST_ARM_SEQ: assert property (s_key1_taken ##1 s_key2_taken |=> ul_armed)
    else $error("Unlock keys in order did not arm the tracker");
  AST_START_ARMED: assert property ($rose(wr_bit) |-> $past(ul_armed))
    else $error("Write started without the unlock sequence");
  AST_WRITE_ENABLE_BIT_GATE: assert property ($rose(wr_bit) |-> $past(write_enable_bit_reg))
    else $error("Write started with write enable clear");
  AST_WRITE_ENABLE_BIT_SW: assert property ($fell(write_enable_bit_reg) |-> $past(ctrl_wr))
    else $error("Write enable cleared without a software write");
  AST_NO_ABORT: assert property (wr_bit && (wcnt_reg != '0) |=> wr_bit)
    else $error("Write cycle ended early");
  AST_DONE: assert property (wr_done |=> !wr_bit && done_flag && !wr_go)
    else $error("Completion did not clear write bit and set flag");
  AST_STICKY: assert property (done_flag && !status_wr |=> done_flag)
    else $error("Done flag dropped without software clear");
  AST_POWER_UP_TIMER: assert property (power_up_timer_busy |-> !wr_go && !$rose(wr_bit))
    else $error("Write started during power-up timer");
  AST_READ_NEXT: assert property (rd_go |-> mu.re ##1 (data_view == mu.rdata))
    else $error("Read byte not in data register next cycle");
  AST_HOLD: assert property (data_src_mem && !rd_go && !data_wr |=> $stable(data_view))
    else $error("Data register changed without read or write");
  AST_PROT: assert property (prot && ext_req && !ext_ack && !ext_denied
                             |=> ext_denied && !ext_ack)
    else $error("Protected array granted to outside path");
  AST_UL_RESET: assert property (unlock_acc && !ul_expect |=> ul_state == NVAC_UL_IDLE)
    else $error("Unexpected unlock access did not reset tracker");

endmodule : nvac_top
`default_nettype wire

// file: nvac_pkg.sv
// Contract
// - Array accessed one byte per address value.
// - Read: address, clear selects, set read bit.
// - Data register holds fetched byte until replaced.
// - Write starts only after 55h, AAh, write bit.
// - Write bit refused unless write enable set.
// - Hardware never clears the write enable bit.
// - Clearing write enable never aborts a write.
// - Write end clears write bit, sets done flag.
// - Done flag stays set until software clears.
// - Power-up clears enable, timer blocks writes.
// - Processor reads work regardless of protection.
// - Protection low denies every non-processor access.
package nvac_pkg;

  // Clock rate and timing figures.
  localparam int unsigned CLK_FREQ_KHZ  = 125000;
  localparam int unsigned POWER_UP_TIMER_TIME_MS  = 64;
  localparam int unsigned POWER_UP_TIMER_CYCLES   = POWER_UP_TIMER_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned WRITE_TIME_US = 4000;
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int          CNT_W         = 24;

  // Widths of the array and of the register port.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int REG_AW = 3;

  // Register offsets.
  localparam logic [REG_AW-1:0] OFS_ADDR   = 3'h0;
  localparam logic [REG_AW-1:0] OFS_DATA   = 3'h1;
  localparam logic [REG_AW-1:0] OFS_CTRL   = 3'h2;
  localparam logic [REG_AW-1:0] OFS_UNLOCK = 3'h3;
  localparam logic [REG_AW-1:0] OFS_STATUS = 3'h4;
  localparam logic [REG_AW-1:0] OFS_MASK   = 3'h5;

  // Control register fields.
  localparam int CTRL_RD   = 0;
  localparam int CTRL_WR   = 1;
  localparam int CTRL_WRITE_ENABLE_BIT = 2;
  localparam int CTRL_CONFIG_SPACE_SELECT = 6;
  localparam int CTRL_PGD  = 7;

  // Status and mask field.
  localparam int STAT_DONE = 0;

  // Unlock keys and reset values.
  localparam logic [DATA_W-1:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [DATA_W-1:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [DATA_W-1:0] RST_BYTE    = 8'h00;

  // Unlock tracker states, Gray coded along the path.
  typedef enum logic [1:0] {
    NVAC_UL_IDLE  = 2'h0,
    NVAC_UL_KEY1  = 2'h1,
    NVAC_UL_ARMED = 2'h3
  } nvac_unlock_t;

endpackage : nvac_pkg

// file: nvac_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
// Port bundle between the access control and the byte array.
interface nvac_mem_if;
  import nvac_pkg::*;
  logic              re;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output re, output we, output addr, output wdata, input rdata);
  modport mem  (input re, input we, input addr, input wdata, output rdata);
endinterface : nvac_mem_if
`default_nettype wire

// file: nvac_mem.sv
`timescale 1ns/10ps
`default_nettype none
module nvac_mem
  import nvac_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  // Array port.
  nvac_mem_if.mem   mp
);

  logic [DATA_W-1:0] array_q [2**ADDR_W];
  logic [DATA_W-1:0] rdata_reg;

  // Each access selects exactly one byte by its address.
  always_ff @(posedge clock) begin
    if (ce && mp.we) begin
      array_q[mp.addr] <= mp.wdata;
    end
  end

  // Read data is registered and kept until the next read.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_reg <= RST_BYTE;
    end else if (ce && mp.re) begin
      rdata_reg <= array_q[mp.addr];
    end
  end

  assign mp.rdata = rdata_reg;

endmodule : nvac_mem
`default_nettype wire

// file: nvac_power_up_timer.sv
`timescale 1ns/10ps
`default_nettype none
module nvac_power_up_timer
  import nvac_pkg::*;
#(
  parameter int unsigned CYCLES = POWER_UP_TIMER_CYCLES
) (
  // Clock, reset and freeze.
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  // Timer still running.
  output var  logic busy
);

  logic [CNT_W-1:0] cnt_reg;
  logic             busy_reg;

  // Restarts on every reset; writes stay blocked until it expires.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b1;
    end else if (ce && busy_reg) begin
      if (cnt_reg == CNT_W'(CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign busy = busy_reg;

endmodule : nvac_power_up_timer
`default_nettype wire

// file: nvac_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module nvac_top_bench;
  import nvac_pkg::*;

  // Shortened counts so that the power-up and write phases fit a short run.
  localparam int unsigned POWER_UP_TIMER_SIM  = 20;
  localparam int unsigned WRITE_SIM = 8;
  localparam int          CYC_LIMIT = 20000;

  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  logic              ce = 1'b1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              data_code_protect_n = 1'b1;
  logic              ext_req = 1'b0;
  logic              ext_we = 1'b0;
  logic [ADDR_W-1:0] ext_addr = '0;
  logic [DATA_W-1:0] ext_wdata = '0;
  logic              ext_ack;
  logic              ext_denied;
  logic [DATA_W-1:0] ext_rdata;
  logic              irq;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;
  logic [7:0]        v;

  // The clock enable stays high: freezing is not part of the access rules.
  nvac_top #(.POWER_UP_TIMER_CYCLES_P(POWER_UP_TIMER_SIM), .WRITE_CYCLES_P(WRITE_SIM)) nvac_top_inst (
    .clock(clock), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_code_protect_n(data_code_protect_n), .ext_req(ext_req), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ack(ext_ack),
    .ext_denied(ext_denied), .ext_rdata(ext_rdata), .irq(irq)
  );

  // Free-running system clock.
  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report and watchdog.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // A hung handshake must not stall the run forever.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == CYC_LIMIT) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // Register port cycles; each strobe lasts one cycle and the slave never waits.
  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data are valid only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Array read through the address, control and data registers.
  task automatic nv_rd(input logic [7:0] a, output logic [7:0] d);
    wr(OFS_ADDR, a);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_DATA, d);
  endtask : nv_rd

  // Unlock-and-start attempt; go tells whether the write is expected to run.
  task automatic try_wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] k1,
                        input logic [7:0] k2, input logic [7:0] pre, input bit rd_mid,
                        input bit go);
    logic [7:0] r;
    // Nothing but the rd_mid read touches the port between the keys and the start.
    wr(OFS_ADDR, a);
    wr(OFS_DATA, d);
    wr(OFS_CTRL, pre);
    wr(OFS_UNLOCK, k1);
    if (rd_mid) begin
      rd(OFS_UNLOCK, r);
      chk("unlock_read", r, 8'h00);
    end
    wr(OFS_UNLOCK, k2);
    wr(OFS_CTRL, 8'h06);
    rd(OFS_CTRL, r);
    chk("ctrl_start", r, go ? 8'h06 : 8'h04);
    repeat (WRITE_SIM + 4) @(posedge clock);
    rd(OFS_CTRL, r);
    chk("ctrl_end", r, 8'h04);
    rd(OFS_STATUS, r);
    chk("status_end", r, go ? 8'h01 : 8'h00);
    wr(OFS_STATUS, 8'h01);
  endtask : try_wr

  // External path request held until the answer pulse, dropped at the next edge.
  task automatic ext_op(input bit we, input logic [7:0] a, input logic [7:0] d,
                        input bit exp_den, input logic [7:0] exp_rd);
    bit seen;
    seen = 1'b0;
    @(posedge clock);
    ext_req <= 1'b1;
    ext_we <= we;
    ext_addr <= a;
    ext_wdata <= d;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clock);
      #1 seen = (ext_ack === 1'b1) || (ext_denied === 1'b1);
    end
    chk("ext_ack", {7'h00, ext_ack}, {7'h00, !exp_den});
    chk("ext_denied", {7'h00, ext_denied}, {7'h00, exp_den});
    if (!we && !exp_den) chk("ext_rdata", ext_rdata, exp_rd);
    @(posedge clock);
    ext_req <= 1'b0;
  endtask : ext_op

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_power(input bit pre_en);
    if (pre_en) wr(OFS_CTRL, 8'h04);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    #1 chk("rdata_rst", reg_rdata, 8'h00);
    chk("irq_rst", {7'h00, irq}, 8'h00);
    rd(OFS_CTRL, v);
    chk("ctrl_rst", v, 8'h00);
    try_wr(8'h05, 8'hEE, UNLOCK_KEY1, UNLOCK_KEY2, 8'h04, 1'b0, 1'b0);
    $display("test power done");
  endtask : t_power

  task automatic t_write_read();
    try_wr(8'h05, 8'h12, UNLOCK_KEY1, UNLOCK_KEY2, 8'h04, 1'b0, 1'b1);
    try_wr(8'h06, 8'h34, UNLOCK_KEY1, UNLOCK_KEY2, 8'h04, 1'b0, 1'b1);
    nv_rd(8'h05, v);
    chk("byte5", v, 8'h12);
    nv_rd(8'h06, v);
    chk("byte6", v, 8'h34);
    repeat (5) @(posedge clock);
    rd(OFS_DATA, v);
    chk("data_hold", v, 8'h34);
    wr(OFS_DATA, 8'h77);
    rd(OFS_DATA, v);
    chk("data_sw", v, 8'h77);
    wr(OFS_ADDR, 8'h05);
    wr(OFS_CTRL, 8'hC1);
    rd(OFS_DATA, v);
    chk("read_sel", v, 8'h77);
    wr(OFS_CTRL, 8'h00);
    $display("test write_read done");
  endtask : t_write_read

  task automatic t_broken();
    try_wr(8'h05, 8'hEE, UNLOCK_KEY2, UNLOCK_KEY1, 8'h04, 1'b0, 1'b0);
    try_wr(8'h05, 8'hEE, UNLOCK_KEY1, 8'h00, 8'h04, 1'b0, 1'b0);
    try_wr(8'h05, 8'hEE, UNLOCK_KEY1, UNLOCK_KEY2, 8'h04, 1'b1, 1'b0);
    try_wr(8'h05, 8'hEE, UNLOCK_KEY1, UNLOCK_KEY2, 8'h00, 1'b0, 1'b0);
    nv_rd(8'h05, v);
    chk("byte5_kept", v, 8'h12);
    $display("test broken done");
  endtask : t_broken

  // Clearing the enable right after the start must not cut the write short.
  task automatic t_abort_irq();
    wr(OFS_ADDR, 8'h07);
    wr(OFS_DATA, 8'h5A);
    wr(OFS_CTRL, 8'h04);
    wr(OFS_UNLOCK, UNLOCK_KEY1);
    wr(OFS_UNLOCK, UNLOCK_KEY2);
    wr(OFS_CTRL, 8'h06);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_CTRL, v);
    chk("ctrl_run", v, 8'h02);
    repeat (WRITE_SIM + 4) @(posedge clock);
    rd(OFS_CTRL, v);
    chk("ctrl_done", v, 8'h00);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    rd(OFS_STATUS, v);
    chk("status_set", v, 8'h01);
    wr(OFS_MASK, 8'h01);
    #1 chk("irq_on", {7'h00, irq}, 8'h01);
    wr(OFS_STATUS, 8'h01);
    #1 chk("irq_off", {7'h00, irq}, 8'h00);
    rd(OFS_MASK, v);
    chk("mask_rd", v, 8'h01);
    wr(OFS_MASK, 8'h00);
    nv_rd(8'h07, v);
    chk("byte7", v, 8'h5A);
    wr(3'h6, 8'hFF);
    rd(3'h6, v);
    chk("unmapped6", v, 8'h00);
    rd(3'h7, v);
    chk("unmapped7", v, 8'h00);
    $display("test abort_irq done");
  endtask : t_abort_irq

  task automatic t_protect();
    data_code_protect_n <= 1'b0;
    repeat (4) @(posedge clock);
    ext_op(1'b0, 8'h05, 8'h00, 1'b1, 8'h00);
    ext_op(1'b1, 8'h05, 8'h99, 1'b1, 8'h00);
    nv_rd(8'h05, v);
    chk("cpu_rd_prot", v, 8'h12);
    try_wr(8'h06, 8'h3C, UNLOCK_KEY1, UNLOCK_KEY2, 8'h04, 1'b0, 1'b1);
    data_code_protect_n <= 1'b1;
    repeat (4) @(posedge clock);
    ext_op(1'b0, 8'h06, 8'h00, 1'b0, 8'h3C);
    ext_op(1'b1, 8'h06, 8'hC3, 1'b0, 8'h00);
    nv_rd(8'h06, v);
    chk("ext_written", v, 8'hC3);
    $display("test protect done");
  endtask : t_protect

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    t_power(1'b0);
    repeat (POWER_UP_TIMER_SIM) @(posedge clock);
    t_write_read();
    t_broken();
    t_abort_irq();
    t_protect();
    t_power(1'b1);
    end_sim();
  end

endmodule : nvac_top_bench
`default_nettype wire
